/* File: rtl/frps_sequencer.sv */
// Flash row erase/program sequencer: control register, unlock key,
// 64-word holding buffer and self-timed operation engine.
// Assumes the CPU drives a one-cycle strobe register port on clk and
// a flash array macro that reacts to the operation strobes.
`timescale 1ns/1ps
module frps_sequencer
    import frps_pkg::*;
#(
    parameter int OP_CYCLES = FRPS_OP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    output logic cpuStall,
    output logic flashErase,
    output logic flashBulk,
    output logic flashProgram,
    output logic [23:0] flashAddr,
    output logic [5:0] bufIndex,
    output logic [23:0] bufWord,
    output logic irq
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic wrCtrl = regWr && (regAddr == FRPS_ADDR_CTRL);
    wire logic wrKey = regWr && (regAddr == FRPS_ADDR_KEY);
    wire logic wrPage = regWr && (regAddr == FRPS_ADDR_PAGE);
    wire logic wrPtr = regWr && (regAddr == FRPS_ADDR_PTR);
    wire logic wrLo = regWr && (regAddr == FRPS_ADDR_LATLO);
    wire logic wrHi = regWr && (regAddr == FRPS_ADDR_LATHI);
    wire logic wrIst = regWr && (regAddr == FRPS_ADDR_IRQST);
    wire logic wrImsk = regWr && (regAddr == FRPS_ADDR_IRQMSK);

    frps_state_e state;
    frps_state_e next_state;
    logic startBit;
    logic programEnable;
    logic sequenceErrorFlag;
    logic eraseBit;
    logic [3:0] operationSelect;
    logic [7:0] tablePage;
    logic [15:0] tablePtr;
    logic [1:0] keyStage;
    logic [31:0] opCount;
    logic [23:0] holdBuf [FRPS_ROW_WORDS];
    logic [15:0] lowStage;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;

    // ------------------------------------------------------------
    // Start qualification
    // ------------------------------------------------------------
    wire logic busy = (state == FRPS_BUSY);
    wire logic startReq = wrCtrl && regWdata[FRPS_BIT_START];
    wire logic keysOk = (keyStage == 2'd2);
    wire logic opErase = eraseBit && (operationSelect == FRPS_OP_BLKERASE);
    wire logic opBulk = eraseBit && (operationSelect == FRPS_OP_BULK);
    wire logic opPgm = !eraseBit && (operationSelect == FRPS_OP_ROWPGM);
    wire logic opValid = opErase || opBulk || opPgm;
    // Launch uses the settings already held, not those in this write
    wire logic launch = startReq && !busy && keysOk && programEnable
                        && opValid;
    wire logic badStart = startReq && !busy && !launch;
    wire logic opDone = busy && (opCount == 32'd0);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            FRPS_IDLE: next_state = launch ? FRPS_BUSY : FRPS_IDLE;
            FRPS_BUSY: next_state = opDone ? FRPS_IDLE : FRPS_BUSY;
            default: next_state = FRPS_IDLE;
        endcase
    end

    // Operation timer, loaded at launch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FRPS_IDLE;
            opCount <= 32'd0;
        end else begin
            state <= next_state;
            if (launch) begin
                opCount <= 32'(OP_CYCLES - 1);
            end else if (busy && opCount != 32'd0) begin
                opCount <= opCount - 32'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Unlock key tracker: any other write or read breaks the pair
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keyStage <= 2'd0;
        end else if (wrKey && regWdata[7:0] == FRPS_KEY_FIRST) begin
            keyStage <= 2'd1;
        end else if (wrKey && keyStage == 2'd1
                     && regWdata[7:0] == FRPS_KEY_SECOND) begin
            keyStage <= 2'd2;
        end else if (regWr || regRd) begin
            keyStage <= 2'd0;
        end
    end

    // ------------------------------------------------------------
    // Control register; rst_n (power-on) clears it, opDone clears the start bit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startBit <= 1'b0;
            programEnable <= 1'b0;
            sequenceErrorFlag <= 1'b0;
            eraseBit <= 1'b0;
            operationSelect <= 4'h0;
        end else begin
            if (launch) begin
                startBit <= 1'b1;
            end else if (opDone) begin
                startBit <= 1'b0;
            end
            // Error set wins over a software clear in the same write
            if (badStart) begin
                sequenceErrorFlag <= 1'b1;
            end else if (wrCtrl && !busy) begin
                sequenceErrorFlag <= regWdata[FRPS_BIT_SEQERR];
            end
            // Settings frozen while busy so the running op is stable
            if (wrCtrl && !busy) begin
                programEnable <= regWdata[FRPS_BIT_PGMEN];
                eraseBit <= regWdata[FRPS_BIT_ERASE];
                operationSelect <= regWdata[FRPS_OP_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // Table pointer and holding buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tablePage <= 8'h00;
            tablePtr <= 16'h0000;
            lowStage <= 16'h0000;
        end else begin
            if (wrPage) begin
                tablePage <= regWdata[7:0];
            end
            if (wrPtr) begin
                tablePtr <= regWdata;
            end else if (wrHi && !busy) begin
                tablePtr <= tablePtr + 16'd2; // Post-increment per word
            end
            if (wrLo && !busy) begin
                lowStage <= regWdata;
            end
        end
    end

    // Buffer has no reset: contents are don't-care until loaded
    always_ff @(posedge clk) begin
        if (wrHi && !busy) begin
            holdBuf[tablePtr[6:1]] <= {regWdata[7:0], lowStage};
        end
    end

    // ------------------------------------------------------------
    // Flash array strobes, one cycle at launch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashErase <= 1'b0;
            flashBulk <= 1'b0;
            flashProgram <= 1'b0;
            flashAddr <= 24'h000000;
            bufIndex <= 6'd0;
            bufWord <= 24'h000000;
        end else begin
            flashErase <= launch && opErase;
            flashBulk <= launch && opBulk;
            flashProgram <= launch && opPgm;
            if (launch) begin
                flashAddr <= {tablePage, tablePtr};
                bufIndex <= 6'd0;
            end else if (busy && opPgm) begin
                bufIndex <= bufIndex + 6'd1; // Stream buffer to array
            end
            bufWord <= holdBuf[bufIndex];
        end
    end

    // ------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------
    wire logic [1:0] irqEvents = {badStart, opDone};
    wire logic [1:0] irqClr = wrIst ? regWdata[1:0] : 2'b00;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= 2'b00;
            irqMask <= 2'b00;
        end else begin
            irqStatus <= (irqStatus & ~irqClr) | irqEvents;
            if (wrImsk) begin
                irqMask <= regWdata[1:0];
            end
        end
    end
    assign irq = |(irqStatus & irqMask);
    assign cpuStall = busy;

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe; key reads as zero
    // ------------------------------------------------------------
    wire logic [15:0] ctrlView = {startBit, programEnable, sequenceErrorFlag,
        6'b000000, eraseBit, 2'b00, operationSelect};
    logic [15:0] rdMux;
    always_comb begin
        case (regAddr)
            FRPS_ADDR_CTRL: rdMux = ctrlView;
            FRPS_ADDR_PAGE: rdMux = {8'h00, tablePage};
            FRPS_ADDR_PTR: rdMux = tablePtr;
            FRPS_ADDR_IRQST: rdMux = {14'h0000, irqStatus};
            FRPS_ADDR_IRQMSK: rdMux = {14'h0000, irqMask};
            default: rdMux = 16'h0000;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            regRdata <= rdMux;
        end else begin
            regRdata <= 16'h0000;
        end
    end
endmodule // frps_sequencer

/* File: rtl/frps_pkg.sv */
// Constants for the flash row erase/program sequencer.
// Assumes a single 20 MHz system clock and a word-wide register port.
package frps_pkg;
    // ------------------------------------------------------------
    // Register map (byte offsets on the register port)
    // ------------------------------------------------------------
    localparam logic [3:0] FRPS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FRPS_ADDR_KEY = 4'h4;
    localparam logic [3:0] FRPS_ADDR_PAGE = 4'h8;
    localparam logic [3:0] FRPS_ADDR_PTR = 4'hC;
    localparam logic [3:0] FRPS_ADDR_LATLO = 4'h1;
    localparam logic [3:0] FRPS_ADDR_LATHI = 4'h2;
    localparam logic [3:0] FRPS_ADDR_IRQST = 4'h5;
    localparam logic [3:0] FRPS_ADDR_IRQMSK = 4'h6;
    // ------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------
    localparam int FRPS_BIT_START = 15;
    localparam int FRPS_BIT_PGMEN = 14;
    localparam int FRPS_BIT_SEQERR = 13;
    localparam int FRPS_BIT_ERASE = 6;
    localparam int FRPS_OP_LSB = 0;
    localparam logic [15:0] FRPS_CTRL_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Operation codes and key values
    // ------------------------------------------------------------
    localparam logic [3:0] FRPS_OP_ROWPGM = 4'h1;
    localparam logic [3:0] FRPS_OP_BLKERASE = 4'h2;
    localparam logic [3:0] FRPS_OP_BULK = 4'hF;
    localparam logic [7:0] FRPS_KEY_FIRST = 8'h55;
    localparam logic [7:0] FRPS_KEY_SECOND = 8'hAA;
    // ------------------------------------------------------------
    // Geometry and timing
    // ------------------------------------------------------------
    localparam int FRPS_ROW_WORDS = 64;
    localparam int FRPS_BLOCK_ROWS = 8;
    localparam int FRPS_CLK_HZ = 20000000;
    localparam int FRPS_OP_TIME_US = 4000;
    localparam int FRPS_OP_CYCLES = FRPS_OP_TIME_US * (FRPS_CLK_HZ / 1000000);
    // Interrupt status bits: done, sequence error
    localparam int FRPS_IRQ_DONE = 0;
    localparam int FRPS_IRQ_ERR = 1;
    typedef enum logic [1:0] {
        FRPS_IDLE = 2'b00,
        FRPS_BUSY = 2'b01
    } frps_state_e;
endpackage

/* File: verif/frps_sequencer_chk.sv */
// Concurrent checks on the sequencer's ports: launch, stall and keys.
// Assumes it is bound to frps_sequencer and sees only its ports.
`timescale 1ns/1ps
module frps_sequencer_chk
    import frps_pkg::*;
#(
    parameter int OP_CYCLES = FRPS_OP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    input wire logic cpuStall,
    input wire logic flashErase,
    input wire logic flashBulk,
    input wire logic flashProgram,
    input wire logic [23:0] flashAddr
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire launch = flashErase | flashBulk | flashProgram;
    wire keyWr = regWr && regAddr == FRPS_ADDR_KEY;
    wire ctrlRd = regRd && regAddr == FRPS_ADDR_CTRL;
    int busyCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Stall length counter; a reset mid-run restarts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busyCnt <= 0;
        else busyCnt <= cpuStall ? busyCnt + 1 : 0;
    end
    property p_launch_stall;
        $rose(cpuStall) |-> launch;
    endproperty
    a_launch_stall: assert property (p_launch_stall) else $error("stall no launch");
    // One cycle of slack either way, since the count origin is a choice
    property p_stall_len;
        $fell(cpuStall) |-> busyCnt >= OP_CYCLES - 1 && busyCnt <= OP_CYCLES + 1;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("bad stall length");
    property p_one_pulse;
        launch |=> !launch;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("launch too long");
    property p_busy_no_launch;
        $past(cpuStall) |-> !launch;
    endproperty
    a_busy_no_launch: assert property (p_busy_no_launch) else $error("relaunch");
    property p_key_seq;
        launch |-> $past(regWr && regAddr == FRPS_ADDR_CTRL && regWdata[15])
            && $past(keyWr && regWdata[7:0] == FRPS_KEY_SECOND, 2)
            && $past(keyWr && regWdata[7:0] == FRPS_KEY_FIRST, 3);
    endproperty
    a_key_seq: assert property (p_key_seq) else $error("launch without keys");
    property p_key_read;
        $past(regRd && regAddr == FRPS_ADDR_KEY) |-> regRdata == 16'h0000;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key readable");
    property p_busy_start;
        $past(ctrlRd && cpuStall) && cpuStall |-> regRdata[FRPS_BIT_START];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("start not set");
    property p_idle_start;
        $past(ctrlRd && !cpuStall) |-> !regRdata[FRPS_BIT_START];
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("start stuck");
    property p_addr_hold;
        cpuStall && $past(cpuStall) |-> $stable(flashAddr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    c_erase: cover property (flashErase);
    c_bulk: cover property (flashBulk);
    c_program: cover property (flashProgram);
endmodule // frps_sequencer_chk
bind frps_sequencer frps_sequencer_chk #(.OP_CYCLES(OP_CYCLES)) frps_sequencer_chk_inst (.*);

/* File: verif/frps_flash_model.sv */
// Flash array stand-in: counts launches and keeps the streamed row.
// Assumes launch strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module frps_flash_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic flashErase,
    input wire logic flashBulk,
    input wire logic flashProgram,
    input wire logic [23:0] flashAddr,
    input wire logic [5:0] bufIndex,
    input wire logic [23:0] bufWord,
    output int nErase = 0,
    output int nBulk = 0,
    output int nPgm = 0,
    output logic [23:0] lastAddr,
    output logic [23:0] row [64]
);
    logic [5:0] prevIdx;
    logic pgmRun = 1'b0;
    // Word trails its index by one cycle, so store against the old index
    always @(posedge clk) begin
        nErase <= nErase + flashErase;
        nBulk <= nBulk + flashBulk;
        nPgm <= nPgm + flashProgram;
        if (flashErase | flashBulk | flashProgram) lastAddr <= flashAddr;
        pgmRun <= flashProgram | (pgmRun & busy);
        prevIdx <= bufIndex;
        if (pgmRun) row[prevIdx] <= bufWord;
    end
endmodule // frps_flash_model

/* File: verif/tb.sv */
// Self-checking bench for the flash sequencer with a flash stand-in.
// Assumes a 50 ns clock and a shortened operation time.
`timescale 1ns/1ps
module tb;
    import frps_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata, d, ptr;
    logic cpuStall, flashErase, flashBulk, flashProgram, irq;
    logic [23:0] flashAddr, bufWord, lastAddr, w;
    logic [23:0] row [64];
    logic [23:0] expRow [64];
    logic [5:0] bufIndex;
    logic [7:0] page;
    logic [2:0] k;
    logic [15:0] ops [8] = '{16'h4001, 16'h4042, 16'h404F, 16'h400F,
        16'h4041, 16'h4002, 16'h0042, 16'h4045};
    int nErase, nBulk, nPgm;
    int err_count = 0;
    int tests_run = 0;
    int seed = 21684;
    int cycles = 0;
    always #25 clk = ~clk;
    // Long enough to stream all 64 buffered words during one program
    frps_sequencer #(.OP_CYCLES(80)) frps_sequencer_inst (.*);
    frps_flash_model frps_flash_model_inst (.busy(cpuStall), .*);
    // ------------------------------------------------------------
    // Bus tasks and expectations
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Strobe stays up so writes can run back to back; idle drops it
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        regRd <= 1'b0;
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
    endtask
    task automatic idle;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic launch(input logic [15:0] c);
        wr(FRPS_ADDR_CTRL, c);
        wr(FRPS_ADDR_KEY, {8'h00, FRPS_KEY_FIRST});
        wr(FRPS_ADDR_KEY, {8'h00, FRPS_KEY_SECOND});
        wr(FRPS_ADDR_CTRL, c | 16'h8000);
        idle();
        #1;
    endtask
    task automatic settle;
        for (int i = 0; i < 200 && cpuStall !== 1'b0; i++) @(posedge clk);
        #1;
    endtask
    // Launch kind as {erase, bulk, program}; empty when refused
    function automatic logic [2:0] kind(input logic [15:0] c);
        kind = {c[6] && c[3:0] == FRPS_OP_BLKERASE, c[6] && c[3:0] ==
            FRPS_OP_BULK, !c[6] && c[3:0] == FRPS_OP_ROWPGM} & {3{c[14]}};
    endfunction
    function automatic logic [15:0] expCtrl(input logic [15:0] c);
        expCtrl = {1'b0, c[14], ~|kind(c), 6'h00, c[6], 2'b00, c[3:0]};
    endfunction
    // Hang guard, well above the expected few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(FRPS_ADDR_CTRL);
        check(d, FRPS_CTRL_RESET);
        page = 8'($random(seed));
        ptr = 16'($random(seed)) & 16'hFF80;
        wr(FRPS_ADDR_PAGE, {8'h00, page});
        wr(FRPS_ADDR_PTR, ptr);
        for (int i = 0; i < 64; i++) begin
            w = 24'($random(seed));
            expRow[i] = w;
            wr(FRPS_ADDR_LATLO, w[15:0]);
            wr(FRPS_ADDR_LATHI, {8'h00, w[23:16]});
        end
        idle();
        check(nPgm, 0);
        foreach (ops[i]) begin
            k = {nErase[0], nBulk[0], nPgm[0]};
            launch(ops[i]);
            check(cpuStall, |kind(ops[i]));
            settle();
            check(k ^ {nErase[0], nBulk[0], nPgm[0]}, kind(ops[i]));
            rd(FRPS_ADDR_CTRL);
            check(d, expCtrl(ops[i]));
        end
        foreach (expRow[i]) check(row[i], expRow[i]);
        check(lastAddr, {page, ptr + 16'h0080});
        for (int m = 0; m < 2; m++) begin
            wr(FRPS_ADDR_CTRL, 16'h4042);
            wr(FRPS_ADDR_KEY, m ? 16'h0055 : 16'h00AA);
            if (m) rd(FRPS_ADDR_KEY);
            if (m) check(d, 16'h0000);
            wr(FRPS_ADDR_KEY, m ? 16'h00AA : 16'h0055);
            wr(FRPS_ADDR_CTRL, 16'hC042);
            idle();
            #1 check(cpuStall, 1'b0);
        end
        wr(FRPS_ADDR_IRQMSK, 16'h0000);
        idle();
        idle();
        #1 check(irq, 1'b0);
        wr(FRPS_ADDR_IRQMSK, 16'h0002);
        idle();
        idle();
        #1 check(irq, 1'b1);
        wr(FRPS_ADDR_IRQST, 16'h0003);
        rd(FRPS_ADDR_IRQST);
        check({irq, d}, 17'h00000);
        rd(4'h3);
        check(d, 16'h0000);
        launch(16'h4042);
        wr(FRPS_ADDR_CTRL, 16'hC001);
        rd(FRPS_ADDR_CTRL);
        check(d, 16'hC042);
        settle();
        rd(FRPS_ADDR_CTRL);
        check(d, 16'h4042);
        launch(16'h4042);
        rst_n <= 1'b0;
        idle();
        rst_n <= 1'b1;
        rd(FRPS_ADDR_CTRL);
        check({cpuStall, d}, 17'h00000);
        report_and_stop();
    end
endmodule // tb
